// >>> shared/arw_pkg.sv
package arw_pkg;

  // ---------------------------------------------------------------
  // Read-only identity of the remapping block
  // ---------------------------------------------------------------
  localparam logic [7:0] CAP_ID = 8'h08;
  localparam logic [4:0] CAP_SUBTYPE = 5'h08;
  localparam logic [1:0] MAP_FORMAT = 2'h0;
  localparam int IO_ADDR_BITS = 25;
  localparam int MAX_DMA = 15;

  // ---------------------------------------------------------------
  // Byte offsets within the block
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_HEADER = 8'h00;
  localparam logic [7:0] OFF_SEC_NP = 8'h04;
  localparam logic [7:0] OFF_SEC_PF = 8'h08;
  localparam logic [7:0] OFF_DMA_FIRST = 8'h0c;
  localparam logic [7:0] DMA_STRIDE = 8'h08;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int HDR_SUBTYPE_LSB = 27;
  localparam int HDR_MAP_LSB = 25;
  localparam int HDR_IO_LSB = 20;
  localparam int HDR_CNT_LSB = 16;
  localparam int HDR_PTR_LSB = 8;
  localparam int CTRL_LSB = 28;
  localparam int SBASE_LSB = 16;
  localparam int CTL_COMPAT = 0;
  localparam int CTL_RELAX = 1;
  localparam int CTL_ISOC = 2;
  localparam int CTL_EN = 3;

  // ---------------------------------------------------------------
  // Warm reset values and write masks
  // ---------------------------------------------------------------
  localparam logic [4:0] RST_IO = 5'h00;
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [19:0] RST_BASE20 = 20'h00000;
  localparam logic [15:0] RST_BASE16 = 16'h0000;
  localparam logic [3:0] DMA_CTRL_WMASK = 4'he;

  // Window compare on the upper bits only, which treats the low base
  // bits as zeros and the low limit bits as ones.
  function automatic logic arw_in_range(logic [19:0] a, logic [19:0] base,
                                        logic [19:0] limit);
    arw_in_range = (a >= base) && (a <= limit);
  endfunction : arw_in_range

  function automatic logic [19:0] arw_rebase(logic [19:0] a,
                                             logic [19:0] from,
                                             logic [19:0] to);
    arw_rebase = a - from + to;
  endfunction : arw_rebase

  // Settings of 25 or more discard every I/O address bit.
  function automatic logic [24:0] arw_io_keep(logic [4:0] sz);
    arw_io_keep = '0;
    for (int i = 0; i < IO_ADDR_BITS; i++) begin
      arw_io_keep[i] = (i < (IO_ADDR_BITS - int'(sz)));
    end
  endfunction : arw_io_keep

endpackage : arw_pkg

// >>> shared/arw_cfg_if.sv
interface arw_cfg_if #(
  parameter int NDMA = 4
);
  logic [3:0] np_ctrl;
  logic [3:0] pf_ctrl;
  logic [19:0] np_base;
  logic [19:0] pf_base;
  logic [NDMA-1:0][3:0] dma_ctrl;
  logic [NDMA-1:0][15:0] dma_pbase;
  logic [NDMA-1:0][15:0] dma_sbase;
  logic [NDMA-1:0][15:0] dma_slimit;

  modport regs (output np_ctrl, pf_ctrl, np_base, pf_base, dma_ctrl,
                dma_pbase, dma_sbase, dma_slimit);
  modport dma (input dma_ctrl, dma_pbase, dma_sbase, dma_slimit);
  modport down (input np_ctrl, pf_ctrl, np_base, pf_base);
endinterface : arw_cfg_if

// >>> hdl/arw_dma_match.sv
module arw_dma_match #(
  parameter int NDMA = 4
) (
  arw_cfg_if.dma cfg,
  input wire logic [39:0] addr_in,
  output logic hit,
  output logic [3:0] hit_idx,
  output logic [39:0] addr_out,
  output logic relax,
  output logic isoc
);
  import arw_pkg::*;

  logic [19:0] nb;

  // Scanned from the top down so the lowest numbered window wins.
  always_comb begin
    hit = 1'b0;
    hit_idx = 4'h0;
    addr_out = addr_in;
    relax = 1'b0;
    isoc = 1'b0;
    nb = '0;
    for (int i = NDMA - 1; i >= 0; i--) begin
      if (cfg.dma_ctrl[i][CTL_EN] && // RULE14
          arw_in_range({4'h0, addr_in[39:24]}, {4'h0, cfg.dma_sbase[i]},
                       {4'h0, cfg.dma_slimit[i]})) begin // RULE16 RULE17
        hit = 1'b1;
        hit_idx = 4'(i);
        nb = arw_rebase({4'h0, addr_in[39:24]}, {4'h0, cfg.dma_sbase[i]},
                        {4'h0, cfg.dma_pbase[i]});
        addr_out = {nb[15:0], addr_in[23:0]}; // RULE15 RULE20
        relax = cfg.dma_ctrl[i][CTL_RELAX]; // RULE13
        isoc = cfg.dma_ctrl[i][CTL_ISOC]; // RULE13
      end
    end
  end
endmodule : arw_dma_match

// >>> hdl/arw_down_map.sv
module arw_down_map (
  arw_cfg_if.down cfg,
  input wire logic [39:0] addr_in,
  input wire logic is_io,
  input wire logic [19:0] pri_np_base,
  input wire logic [19:0] pri_np_limit,
  input wire logic [19:0] pri_pf_base,
  input wire logic [19:0] pri_pf_limit,
  output logic active,
  output logic [39:0] addr_out,
  output logic set_compat,
  output logic clr_coherent,
  output logic set_isoc
);
  import arw_pkg::*;

  logic np_hit;
  logic pf_hit;
  logic [3:0] ctl;
  logic [19:0] from;
  logic [19:0] to;

  assign np_hit = !is_io && arw_in_range(addr_in[39:20], pri_np_base,
                                         pri_np_limit);
  assign pf_hit = !is_io && arw_in_range(addr_in[39:20], pri_pf_base,
                                         pri_pf_limit);

  // Overlapping primary windows are a setup error; the non-prefetchable
  // window is given precedence so the result is still defined.
  always_comb begin
    ctl = 4'h0;
    from = '0;
    to = '0;
    if (np_hit) begin
      ctl = cfg.np_ctrl;
      from = pri_np_base;
      to = cfg.np_base;
    end else if (pf_hit) begin
      ctl = cfg.pf_ctrl;
      from = pri_pf_base;
      to = cfg.pf_base;
    end
  end

  assign active = (np_hit || pf_hit) && ctl[CTL_EN]; // RULE11
  assign addr_out = active ?
      {arw_rebase(addr_in[39:20], from, to), addr_in[19:0]} : // RULE12 RULE21
      addr_in;
  assign set_compat = active && ctl[CTL_COMPAT]; // RULE8
  assign clr_coherent = active && ctl[CTL_RELAX]; // RULE9
  assign set_isoc = active && ctl[CTL_ISOC]; // RULE10
endmodule : arw_down_map

// >>> hdl/arw_remap.sv
//
// Behaviour
// RULE1 - Capability identifier reads fixed 08h
// RULE2 - Next pointer reads configured value, 00h last
// RULE3 - Count field reports implemented DMA sets
// RULE4 - I/O size zero forwards all 25 bits
// RULE5 - Discarded I/O address bits driven as zero
// RULE6 - Mapping format reads zero
// RULE7 - Subtype reads address mapping extension code
// RULE8 - Control bit 0 sets compat downstream
// RULE9 - Control bit 1 clears coherent downstream
// RULE10 - Control bit 2 sets isochronous downstream
// RULE11 - Control bit 3 gates downstream modification
// RULE12 - Secondary bases supply bits 39:20
// RULE13 - DMA bits 1,2 relax coherent, set isoc
// RULE14 - DMA enable clear means never match
// RULE15 - Primary base supplies upstream bits 39:24
// RULE16 - Secondary base/limit bound upstream window
// RULE17 - Low base zeros, low limit ones
// RULE18 - Misses pass upstream unchanged
// RULE19 - Writable fields clear on warm reset
// RULE20 - DMA hit keeps offset, swaps base
// RULE21 - Downstream hit relocated keeping offset
module arw_remap #(
  parameter int NDMA = 4,
  parameter logic [7:0] NEXT_PTR = 8'h00
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_rd_en,
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid,
  input wire logic isoc_fc_en,
  input wire logic [19:0] pri_np_base,
  input wire logic [19:0] pri_np_limit,
  input wire logic [19:0] pri_pf_base,
  input wire logic [19:0] pri_pf_limit,
  input wire logic dn_valid,
  input wire logic [39:0] dn_addr,
  input wire logic dn_is_io,
  input wire logic dn_compat,
  input wire logic dn_coherent,
  input wire logic dn_isoc,
  output logic dn_out_valid,
  output logic [39:0] dn_out_addr,
  output logic dn_out_is_io,
  output logic dn_out_compat,
  output logic dn_out_coherent,
  output logic dn_out_isoc,
  output logic dn_out_isoc_vc,
  input wire logic up_valid,
  input wire logic [39:0] up_addr,
  input wire logic up_coherent,
  input wire logic up_isoc,
  output logic up_out_valid,
  output logic [39:0] up_out_addr,
  output logic up_out_coherent,
  output logic up_out_isoc,
  output logic up_out_isoc_vc,
  output logic up_out_dma_hit
);
  import arw_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [4:0] io_size;
    logic [3:0] np_ctrl;
    logic [3:0] pf_ctrl;
    logic [19:0] np_base;
    logic [19:0] pf_base;
    logic [NDMA-1:0][3:0] dma_ctrl;
    logic [NDMA-1:0][15:0] dma_pbase;
    logic [NDMA-1:0][15:0] dma_sbase;
    logic [NDMA-1:0][15:0] dma_slimit;
    logic rd_valid;
    logic [31:0] rdata;
    logic dn_valid;
    logic [39:0] dn_addr;
    logic dn_is_io;
    logic dn_compat;
    logic dn_coherent;
    logic dn_isoc;
    logic dn_isoc_vc;
    logic up_valid;
    logic [39:0] up_addr;
    logic up_coherent;
    logic up_isoc;
    logic up_isoc_vc;
    logic up_hit;
  } arw_state_t;

  localparam arw_state_t RESET_STATE = '{
    io_size: RST_IO,
    np_ctrl: RST_CTRL,
    pf_ctrl: RST_CTRL,
    np_base: RST_BASE20,
    pf_base: RST_BASE20,
    dma_ctrl: {NDMA{RST_CTRL}},
    dma_pbase: {NDMA{RST_BASE16}},
    dma_sbase: {NDMA{RST_BASE16}},
    dma_slimit: {NDMA{RST_BASE16}},
    default: '0
  };

  arw_state_t state_q;
  arw_state_t state_d;

  // ---------------------------------------------------------------
  // Configuration access helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] arw_merge(logic [31:0] old,
                                            logic [31:0] wdata,
                                            logic [3:0] be);
    arw_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        arw_merge[8*b +: 8] = wdata[8*b +: 8];
      end
    end
  endfunction : arw_merge

  function automatic logic [31:0] arw_win_word(logic [3:0] ctl,
                                               logic [19:0] base);
    arw_win_word = '0;
    arw_win_word[CTRL_LSB +: 4] = ctl;
    arw_win_word[19:0] = base;
  endfunction : arw_win_word

  logic [7:0] word_addr;
  logic [7:0] dma_rel;
  logic dma_sel;
  logic [4:0] dma_idx;
  logic [31:0] hdr_word;
  logic [31:0] rd_word;
  logic [31:0] merged;
  logic [31:0] dma_ctl_word;
  logic [31:0] dma_pair_word;

  // Low address bits are ignored: every register is one aligned word.
  assign word_addr = {cfg_addr[7:2], 2'b00};
  assign dma_rel = word_addr - OFF_DMA_FIRST;
  assign dma_sel = (word_addr >= OFF_DMA_FIRST) &&
                   (dma_rel < 8'(NDMA * int'(DMA_STRIDE)));
  assign dma_idx = dma_rel[7:3];

  always_comb begin
    hdr_word = '0;
    hdr_word[HDR_SUBTYPE_LSB +: 5] = CAP_SUBTYPE; // RULE7
    hdr_word[HDR_MAP_LSB +: 2] = MAP_FORMAT; // RULE6
    hdr_word[HDR_IO_LSB +: 5] = state_q.io_size;
    hdr_word[HDR_CNT_LSB +: 4] = 4'(NDMA); // RULE3
    hdr_word[HDR_PTR_LSB +: 8] = NEXT_PTR; // RULE2
    hdr_word[7:0] = CAP_ID; // RULE1
  end

  always_comb begin
    dma_ctl_word = '0;
    dma_pair_word = '0;
    for (int i = 0; i < NDMA; i++) begin
      if (dma_idx == 5'(i)) begin
        dma_ctl_word[CTRL_LSB +: 4] = state_q.dma_ctrl[i];
        dma_ctl_word[15:0] = state_q.dma_pbase[i];
        dma_pair_word[SBASE_LSB +: 16] = state_q.dma_sbase[i];
        dma_pair_word[15:0] = state_q.dma_slimit[i];
      end
    end
  end

  // Unmapped words inside the block read as zero.
  always_comb begin
    if (word_addr == OFF_HEADER) begin
      rd_word = hdr_word;
    end else if (word_addr == OFF_SEC_NP) begin
      rd_word = arw_win_word(state_q.np_ctrl, state_q.np_base);
    end else if (word_addr == OFF_SEC_PF) begin
      rd_word = arw_win_word(state_q.pf_ctrl, state_q.pf_base);
    end else if (dma_sel && !dma_rel[2]) begin
      rd_word = dma_ctl_word;
    end else if (dma_sel) begin
      rd_word = dma_pair_word;
    end else begin
      rd_word = '0;
    end
  end

  assign merged = arw_merge(rd_word, cfg_wdata, cfg_be);

  // ---------------------------------------------------------------
  // Address mapping units
  // ---------------------------------------------------------------
  arw_cfg_if #(.NDMA(NDMA)) cfg_bus ();

  assign cfg_bus.np_ctrl = state_q.np_ctrl;
  assign cfg_bus.pf_ctrl = state_q.pf_ctrl;
  assign cfg_bus.np_base = state_q.np_base;
  assign cfg_bus.pf_base = state_q.pf_base;
  assign cfg_bus.dma_ctrl = state_q.dma_ctrl;
  assign cfg_bus.dma_pbase = state_q.dma_pbase;
  assign cfg_bus.dma_sbase = state_q.dma_sbase;
  assign cfg_bus.dma_slimit = state_q.dma_slimit;

  logic dm_active;
  logic [39:0] dm_addr;
  logic dm_compat;
  logic dm_relax;
  logic dm_isoc;
  logic um_hit;
  logic [3:0] um_idx;
  logic [39:0] um_addr;
  logic um_relax;
  logic um_isoc;

  arw_down_map u_down (
    .cfg(cfg_bus),
    .addr_in(dn_addr),
    .is_io(dn_is_io),
    .pri_np_base(pri_np_base),
    .pri_np_limit(pri_np_limit),
    .pri_pf_base(pri_pf_base),
    .pri_pf_limit(pri_pf_limit),
    .active(dm_active),
    .addr_out(dm_addr),
    .set_compat(dm_compat),
    .clr_coherent(dm_relax),
    .set_isoc(dm_isoc)
  );

  arw_dma_match #(.NDMA(NDMA)) u_dma (
    .cfg(cfg_bus),
    .addr_in(up_addr),
    .hit(um_hit),
    .hit_idx(um_idx),
    .addr_out(um_addr),
    .relax(um_relax),
    .isoc(um_isoc)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.rd_valid = cfg_rd_en;
    if (cfg_rd_en) begin
      state_d.rdata = rd_word;
    end
    // Read-only fields are simply not stored, so writes to them vanish.
    if (cfg_wr_en) begin
      if (word_addr == OFF_HEADER) begin
        state_d.io_size = merged[HDR_IO_LSB +: 5]; // RULE4
      end else if (word_addr == OFF_SEC_NP) begin
        state_d.np_ctrl = merged[CTRL_LSB +: 4];
        state_d.np_base = merged[19:0];
      end else if (word_addr == OFF_SEC_PF) begin
        state_d.pf_ctrl = merged[CTRL_LSB +: 4];
        state_d.pf_base = merged[19:0];
      end else if (dma_sel) begin
        for (int i = 0; i < NDMA; i++) begin
          if (dma_idx == 5'(i) && !dma_rel[2]) begin
            state_d.dma_ctrl[i] = merged[CTRL_LSB +: 4] & DMA_CTRL_WMASK;
            state_d.dma_pbase[i] = merged[15:0];
          end else if (dma_idx == 5'(i)) begin
            state_d.dma_sbase[i] = merged[SBASE_LSB +: 16];
            state_d.dma_slimit[i] = merged[15:0];
          end
        end
      end
    end

    // Downstream path, one cycle of latency.
    state_d.dn_valid = dn_valid;
    state_d.dn_is_io = dn_is_io;
    state_d.dn_addr = dm_addr;
    state_d.dn_compat = dn_compat || dm_compat; // RULE8
    state_d.dn_coherent = dn_coherent && !dm_relax; // RULE9
    state_d.dn_isoc = dn_isoc || dm_isoc; // RULE10
    if (dn_is_io) begin
      state_d.dn_addr = {15'h0000, dn_addr[24:0] & // RULE5
                         arw_io_keep(state_q.io_size)}; // RULE4
    end
    state_d.dn_isoc_vc = state_d.dn_isoc && isoc_fc_en; // RULE10

    // Upstream path, one cycle of latency.
    state_d.up_valid = up_valid;
    state_d.up_hit = um_hit;
    state_d.up_addr = um_addr; // RULE18 RULE20
    state_d.up_coherent = up_coherent && !um_relax; // RULE13
    state_d.up_isoc = up_isoc || um_isoc; // RULE13
    state_d.up_isoc_vc = state_d.up_isoc && isoc_fc_en; // RULE13
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= RESET_STATE; // RULE19
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cfg_rdata = state_q.rdata;
  assign cfg_rd_valid = state_q.rd_valid;
  assign dn_out_valid = state_q.dn_valid;
  assign dn_out_addr = state_q.dn_addr;
  assign dn_out_is_io = state_q.dn_is_io;
  assign dn_out_compat = state_q.dn_compat;
  assign dn_out_coherent = state_q.dn_coherent;
  assign dn_out_isoc = state_q.dn_isoc;
  assign dn_out_isoc_vc = state_q.dn_isoc_vc;
  assign up_out_valid = state_q.up_valid;
  assign up_out_addr = state_q.up_addr;
  assign up_out_coherent = state_q.up_coherent;
  assign up_out_isoc = state_q.up_isoc;
  assign up_out_isoc_vc = state_q.up_isoc_vc;
  assign up_out_dma_hit = state_q.up_hit;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_CAP_HEADER: assert property (@(posedge clk) disable iff (reset)
    $past(cfg_rd_en && word_addr == OFF_HEADER) |->
      cfg_rdata[7:0] == 8'h08 && cfg_rdata[15:8] == NEXT_PTR) // RULE1 RULE2
    else $error("Header identity or pointer read wrong.");

  AST_CAP_FIELDS: assert property (@(posedge clk) disable iff (reset)
    $past(cfg_rd_en && word_addr == OFF_HEADER) |->
      cfg_rdata[31:25] == 7'h20 && cfg_rdata[19:16] == 4'(NDMA)) // RULE3 RULE6 RULE7
    else $error("Header subtype, format or count read wrong.");

  AST_IO_FULL: assert property (@(posedge clk) disable iff (reset)
    $past(dn_valid && dn_is_io && state_q.io_size == 5'h00) |->
      dn_out_addr == {15'h0000, $past(dn_addr[24:0])}) // RULE4
    else $error("I/O address not forwarded whole at size zero.");

  AST_IO_ZERO: assert property (@(posedge clk) disable iff (reset)
    dn_out_valid && dn_out_is_io |->
      (dn_out_addr[24:0] & ~arw_io_keep($past(state_q.io_size))) == '0 &&
      dn_out_addr[39:25] == '0) // RULE5
    else $error("Discarded I/O address bit not zero.");

  AST_WARM_CLEAR: assert property (@(posedge clk) disable iff (reset)
    $past(reset) |-> state_q.io_size == '0 && state_q.np_ctrl == '0 &&
      state_q.pf_base == '0 && state_q.dma_ctrl == '0 &&
      state_q.dma_slimit == '0) // RULE19
    else $error("Writable field not clear after reset.");

  AST_DN_GATE: assert property (@(posedge clk) disable iff (reset)
    $past(dn_valid && !dn_is_io && !dm_active) |->
      dn_out_addr == $past(dn_addr) &&
      dn_out_coherent == $past(dn_coherent) &&
      dn_out_compat == $past(dn_compat)) // RULE11
    else $error("Downstream cycle modified outside an enabled window.");

  AST_DN_ATTR: assert property (@(posedge clk) disable iff (reset)
    $past(dn_valid && dm_active && dn_addr[39:20] >= pri_np_base &&
          dn_addr[39:20] <= pri_np_limit) |->
      dn_out_compat == ($past(dn_compat) || $past(state_q.np_ctrl[0])) &&
      (dn_out_coherent == ($past(dn_coherent) &&
                           !$past(state_q.np_ctrl[1]))) &&
      dn_out_isoc_vc == (dn_out_isoc && $past(isoc_fc_en))) // RULE8 RULE9 RULE10
    else $error("Downstream attributes wrong in the window.");

  AST_DN_RELOC: assert property (@(posedge clk) disable iff (reset)
    $past(dn_valid && dm_active && dn_addr[39:20] >= pri_np_base &&
          dn_addr[39:20] <= pri_np_limit) |->
      dn_out_addr[19:0] == $past(dn_addr[19:0]) &&
      dn_out_addr[39:20] == $past(dn_addr[39:20] - pri_np_base +
                                  state_q.np_base)) // RULE12 RULE21
    else $error("Downstream relocation lost offset or base.");

  AST_UP_PASS: assert property (@(posedge clk) disable iff (reset)
    $past(up_valid && !um_hit) |-> up_out_addr == $past(up_addr) &&
      up_out_coherent == $past(up_coherent) &&
      up_out_isoc == $past(up_isoc) && !up_out_dma_hit) // RULE18
    else $error("Upstream miss was modified.");

  AST_UP_ENABLE: assert property (@(posedge clk) disable iff (reset)
    um_hit |-> state_q.dma_ctrl[um_idx][3] &&
      up_addr[39:24] >= state_q.dma_sbase[um_idx] &&
      up_addr[39:24] <= state_q.dma_slimit[um_idx]) // RULE14 RULE16 RULE17
    else $error("Disabled or out of range DMA window matched.");

  AST_UP_XLATE: assert property (@(posedge clk) disable iff (reset)
    $past(up_valid && um_hit) |->
      up_out_addr[23:0] == $past(up_addr[23:0]) &&
      up_out_addr[39:24] == $past(up_addr[39:24] -
        state_q.dma_sbase[um_idx] + state_q.dma_pbase[um_idx]) &&
      up_out_coherent == ($past(up_coherent) &&
                          !$past(state_q.dma_ctrl[um_idx][1]))) // RULE13 RULE15 RULE20
    else $error("Upstream DMA translation wrong.");

endmodule : arw_remap

// >>> tb/arw_host_model.sv
module arw_host_model (
  input logic fc_on,
  output logic isoc_fc_en,
  output logic [19:0] pri_np_base,
  output logic [19:0] pri_np_limit,
  output logic [19:0] pri_pf_base,
  output logic [19:0] pri_pf_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------
  // Primary bridge windows
  // ----------------------------
  // The two windows do not overlap, so the non-prefetch priority of the
  // design is never what decides a hit here.
  assign isoc_fc_en = fc_on;
  assign pri_np_base = 20'h00100;
  assign pri_np_limit = 20'h001ff;
  assign pri_pf_base = 20'h00400;
  assign pri_pf_limit = 20'h004ff;
endmodule : arw_host_model

// >>> tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import arw_pkg::*;
  localparam int ND = 4;
  localparam logic [7:0] NP = 8'h40;
  logic clk, reset, cfg_rd_en, cfg_wr_en, cfg_rd_valid, isoc_fc_en;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [19:0] pri_np_base, pri_np_limit, pri_pf_base, pri_pf_limit;
  logic dn_valid, dn_is_io, dn_compat, dn_coherent, dn_isoc;
  logic [39:0] dn_addr, dn_out_addr, up_addr, up_out_addr;
  logic dn_out_valid, dn_out_is_io, dn_out_compat, dn_out_coherent;
  logic dn_out_isoc, dn_out_isoc_vc, up_valid, up_coherent, up_isoc;
  logic up_out_valid, up_out_coherent, up_out_isoc, up_out_isoc_vc;
  logic up_out_dma_hit, fc_on;
  int n_mismatch = 0;
  int tests_run = 0;

  arw_host_model host (.fc_on, .isoc_fc_en, .pri_np_base, .pri_np_limit,
    .pri_pf_base, .pri_pf_limit);
  arw_remap #(.NDMA(ND), .NEXT_PTR(NP)) dut (.clk, .reset, .cfg_rd_en,
    .cfg_wr_en, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rd_valid,
    .isoc_fc_en, .pri_np_base, .pri_np_limit, .pri_pf_base, .pri_pf_limit,
    .dn_valid, .dn_addr, .dn_is_io, .dn_compat, .dn_coherent, .dn_isoc,
    .dn_out_valid, .dn_out_addr, .dn_out_is_io, .dn_out_compat,
    .dn_out_coherent, .dn_out_isoc, .dn_out_isoc_vc, .up_valid, .up_addr,
    .up_coherent, .up_isoc, .up_out_valid, .up_out_addr, .up_out_coherent,
    .up_out_isoc, .up_out_isoc_vc, .up_out_dma_hit);

  always #10 clk = ~clk;

  // ----------------------------
  // Bus cycles and comparison
  // ----------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    @(negedge clk);
    cfg_wr_en = 1'h1;
    cfg_addr = a;
    cfg_wdata = d;
    cfg_be = be;
    @(negedge clk);
    cfg_wr_en = 1'h0;
  endtask : wr

  // Read data is looked at in the one cycle that the valid pulse stands.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    cfg_rd_en = 1'h1;
    cfg_addr = a;
    @(negedge clk);
    cfg_rd_en = 1'h0;
    chk(40'(cfg_rd_valid), 40'h1);
    chk(40'(cfg_rdata), 40'(e));
  endtask : rd

  task automatic dn(input logic [39:0] a, input logic io,
                    input logic [39:0] ea, input logic [5:0] ef);
    @(negedge clk);
    dn_valid = 1'h1;
    dn_addr = a;
    dn_is_io = io;
    @(negedge clk);
    dn_valid = 1'h0;
    chk(dn_out_addr, ea);
    chk(40'({dn_out_valid, dn_out_is_io, dn_out_compat, dn_out_coherent,
             dn_out_isoc, dn_out_isoc_vc}), 40'(ef));
  endtask : dn

  task automatic up(input logic [39:0] a, input logic [39:0] ea,
                    input logic [4:0] ef);
    @(negedge clk);
    up_valid = 1'h1;
    up_addr = a;
    @(negedge clk);
    up_valid = 1'h0;
    chk(up_out_addr, ea);
    chk(40'({up_out_valid, up_out_coherent, up_out_isoc, up_out_isoc_vc,
             up_out_dma_hit}), 40'(ef));
  endtask : up

  function automatic logic [31:0] hdr(input logic [4:0] io);
    hdr = {CAP_SUBTYPE, MAP_FORMAT, io, 4'(ND), NP, CAP_ID};
  endfunction : hdr

  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_io;
    rd(8'h00, hdr(5'h00));
    rd(8'h14, 32'h0);
    dn(40'hffffffffff, 1'h1, 40'h0001ffffff, 6'h34);
    wr(8'h00, 32'hff6fffff, 4'hc);
    rd(8'h00, hdr(5'h16));
    dn(40'hffffffffff, 1'h1, 40'h0000000007, 6'h34);
  endtask : t_io

  task automatic t_dn;
    wr(8'h04, 32'hf0000abc, 4'hf);
    dn(40'h0012345678, 1'h0, 40'h00adf45678, 6'h2b);
    wr(8'h04, 32'h70000abc, 4'hf);
    dn(40'h0012345678, 1'h0, 40'h0012345678, 6'h24);
    wr(8'h08, 32'h80000200, 4'hf);
    dn(40'h0040012345, 1'h0, 40'h0020012345, 6'h24);
    wr(8'h08, 32'hc0000200, 4'hf);
    dn(40'h00400fffff, 1'h0, 40'h00200fffff, 6'h27);
    fc_on = 1'h0;
    dn(40'h00400fffff, 1'h0, 40'h00200fffff, 6'h26);
    fc_on = 1'h1;
  endtask : t_dn

  task automatic t_dma;
    wr(8'h0c, 32'hf0000030, 4'hf);
    wr(8'h10, 32'h00100011, 4'hf);
    rd(8'h0c, 32'he0000030);
    up(40'h0011ffffff, 40'h0031ffffff, 5'h17);
    up(40'h0010000000, 40'h0030000000, 5'h17);
    up(40'h0012000000, 40'h0012000000, 5'h18);
    wr(8'h0c, 32'h70000030, 4'hf);
    up(40'h0011ffffff, 40'h0011ffffff, 5'h18);
  endtask : t_dma

  // A warm reset in mid-run must clear the header, 04h and 10h words written above.
  task automatic t_rerst;
    @(negedge clk);
    reset = 1'h1;
    repeat (2) @(negedge clk);
    reset = 1'h0;
    rd(8'h00, hdr(5'h00));
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
  endtask : t_rerst

  task automatic report_and_stop;
    $display("mismatches=%0d checks=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    clk = 1'h0;
    reset = 1'h1;
    fc_on = 1'h1;
    {cfg_rd_en, cfg_wr_en, cfg_addr, cfg_be, cfg_wdata} = '0;
    {dn_valid, dn_addr, dn_is_io, dn_compat, dn_isoc} = '0;
    {up_valid, up_addr, up_isoc} = '0;
    dn_coherent = 1'h1;
    up_coherent = 1'h1;
    repeat (2) @(negedge clk);
    reset = 1'h0;
    t_io();
    t_dn();
    t_dma();
    t_rerst();
    report_and_stop();
  end
endmodule : tb_top
